//--- core/iox_top.sv
`timescale 1ns/1ps
`include "iox_map.svh"
module iox_top (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // serial bus, open drain
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address straps
    input wire logic addr_sel_lo,
    input wire logic addr_sel_hi,
    // interrupt, open drain, active low
    output logic int_n_out,
    output logic int_n_oe,
    // port 0 pins
    input wire iox_pkg::iox_byte_t port0_pin_in,
    output iox_pkg::iox_byte_t port0_pin_out,
    output iox_pkg::iox_byte_t port0_pin_oe,
    // port 1 pins
    input wire iox_pkg::iox_byte_t port1_pin_in,
    output iox_pkg::iox_byte_t port1_pin_out,
    output iox_pkg::iox_byte_t port1_pin_oe
);
    import iox_pkg::*;

    logic [1:0] rs_q;
    logic rst_n;
    iox_top_s_t q, d;
    logic [1:0] wr, cap, mism;
    iox_byte_t in_val [2];
    iox_byte_t out_v [2];
    iox_byte_t pol_v [2];
    iox_byte_t dir_v [2];
    iox_byte_t pins [2];
    iox_byte_t pouts [2];
    iox_byte_t poes [2];
    logic rise, fall, start, stop, addr_hit, sda_now;
    iox_byte_t rd_byte;

    // same path for power-on and pin reset; release is synchronised
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rs_q <= 2'b00;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    assign pins[0] = port0_pin_in;
    assign pins[1] = port1_pin_in;

    for (genvar i = 0; i < 2; i++) begin : g_port
        iox_port #(.WIDTH(8)) u_port (
            .clock(clock),
            .rst_n(rst_n),
            .wr(wr[i]),
            .kind(q.ptr[2:1]),
            .wr_data(q.sh),
            .cap(cap[i]),
            .pin_in(pins[i]),
            .pin_out(pouts[i]),
            .pin_oe(poes[i]),
            .in_val(in_val[i]),
            .out_v(out_v[i]),
            .pol_v(pol_v[i]),
            .dir_v(dir_v[i]),
            .mism(mism[i])
        );
    end

    assign sda_now = sda_in;
    assign rise = scl && !q.scl_p;
    assign fall = !scl && q.scl_p;
    assign start = scl && q.scl_p && q.sda_p && !sda_now;
    assign stop = scl && q.scl_p && !q.sda_p && sda_now;
    assign addr_hit = q.sh[7:1] == {`IOX_ADDR_HI, addr_sel_hi, addr_sel_lo};

    always_comb begin
        unique case (q.ptr[2:1])
            `IOX_KIND_IN: rd_byte = in_val[q.ptr[0]];
            `IOX_KIND_OUT: rd_byte = out_v[q.ptr[0]];
            `IOX_KIND_POL: rd_byte = pol_v[q.ptr[0]];
            `IOX_KIND_DIR: rd_byte = dir_v[q.ptr[0]];
        endcase
    end

    always_comb begin
        d = q;
        wr = 2'b00;
        cap = 2'b00;
        d.scl_p = scl;
        d.sda_p = sda_now;
        d.low = 1'b0;
        d.int_oe = |mism;
        if (start) begin
            d.st = IOX_ADDR;
            d.cnt = 3'h0;
            d.full = 1'b0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.st = IOX_IDLE;
            d.sda_oe = 1'b0;
        end else if (rise) begin
            unique case (q.st)
                IOX_ADDR, IOX_CMD, IOX_WR: begin
                    d.sh = {q.sh[6:0], sda_now};
                    d.cnt = q.cnt + 3'h1;
                    d.full = q.cnt == 3'h7;
                end
                IOX_RD: begin
                    d.cnt = q.cnt + 3'h1;
                    d.full = q.cnt == 3'h7;
                end
                // master ack keeps the read going, nack ends it
                IOX_MACK: d.nxt = sda_now ? IOX_IDLE : IOX_RD;
                default: ;
            endcase
        end else if (fall) begin
            unique case (q.st)
                IOX_ADDR: begin
                    if (q.full) begin
                        d.full = 1'b0;
                        if (addr_hit) begin
                            d.st = IOX_ACK;
                            d.sda_oe = 1'b1;
                            d.nxt = q.sh[0] ? IOX_RD : IOX_CMD;
                        end else begin
                            d.st = IOX_IDLE;
                        end
                    end
                end
                IOX_CMD: begin
                    if (q.full) begin
                        d.full = 1'b0;
                        d.ptr = q.sh[2:0];
                        d.st = IOX_ACK;
                        d.sda_oe = 1'b1;
                        d.nxt = IOX_WR;
                    end
                end
                IOX_WR: begin
                    if (q.full) begin
                        d.full = 1'b0;
                        wr[q.ptr[0]] = 1'b1;
                        d.st = IOX_ACK;
                        d.sda_oe = 1'b1;
                        d.nxt = IOX_WR;
                    end
                end
                IOX_ACK, IOX_MACK: begin
                    d.st = q.nxt;
                    d.sda_oe = 1'b0;
                    d.cnt = 3'h0;
                    // reads keep hitting the last commanded register
                    if (q.nxt == IOX_RD) begin
                        d.sh = rd_byte;
                        d.sda_oe = !rd_byte[7];
                        if (q.ptr[2:1] == `IOX_KIND_IN) begin
                            cap[q.ptr[0]] = 1'b1;
                        end
                    end
                end
                IOX_RD: begin
                    if (q.full) begin
                        d.full = 1'b0;
                        d.st = IOX_MACK;
                        d.sda_oe = 1'b0;
                    end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oe = !q.sh[6];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: IOX_IDLE, nxt: IOX_IDLE, cnt: 3'h0, full: 1'b0, sh: 8'h00,
                   ptr: 3'h0, sda_oe: 1'b0, scl_p: 1'b1, sda_p: 1'b1,
                   int_oe: 1'b0, low: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign sda_out = q.low;
    assign sda_oe = q.sda_oe;
    assign int_n_out = q.low;
    assign int_n_oe = q.int_oe;
    assign port0_pin_out = pouts[0];
    assign port0_pin_oe = poes[0];
    assign port1_pin_out = pouts[1];
    assign port1_pin_oe = poes[1];

    sequence s_byte_end(iox_state_t s);
        q.st == s && fall && q.full && !start && !stop;
    endsequence

    sequence s_acking;
        q.st == IOX_ACK && sda_oe;
    endsequence

    property p_int_set;
        @(posedge clock) disable iff (!rst_n) |mism |=> !int_n_out && int_n_oe;
    endproperty
    a_int_set: assert property (p_int_set) else $error("interrupt not pulled low");

    property p_int_clr;
        @(posedge clock) disable iff (!rst_n) !(|mism) |=> !int_n_oe;
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("interrupt not released");

    property p_addr_ack;
        @(posedge clock) disable iff (!rst_n) s_byte_end(IOX_ADDR) ##0 addr_hit |=> s_acking;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

    property p_addr_ign;
        @(posedge clock) disable iff (!rst_n)
            s_byte_end(IOX_ADDR) ##0 !addr_hit |=> q.st == IOX_IDLE && !sda_oe;
    endproperty
    a_addr_ign: assert property (p_addr_ign) else $error("foreign address acked");

    property p_cmd;
        @(posedge clock) disable iff (!rst_n)
            s_byte_end(IOX_CMD) |=> q.ptr == $past(q.sh[2:0]) ##0 s_acking;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command byte not taken");

    property p_ptr_hold;
        @(posedge clock) disable iff (!rst_n) !(q.st == IOX_CMD && fall) |=> $stable(q.ptr);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("register pointer moved");

    property p_rst;
        @(posedge clock) $rose(rst_n) |-> q.st == IOX_IDLE && !sda_oe &&
            port0_pin_oe == 8'h00 && port1_pin_oe == 8'h00 && port0_pin_out == 8'hff;
    endproperty
    a_rst: assert property (p_rst) else $error("reset defaults wrong");

    property p_rd_load;
        @(posedge clock) disable iff (!rst_n)
            q.st == IOX_ACK && q.nxt == IOX_RD && fall && !start && !stop
            |=> q.sh == $past(rd_byte) && sda_oe == !q.sh[7];
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("read byte not loaded");
endmodule : iox_top

//--- core/iox_map.svh
`ifndef IOX_MAP_SVH
`define IOX_MAP_SVH

// upper five bits of the seven-bit slave address
`define IOX_ADDR_HI 5'h1d
// register kind, command bits [2:1]; bit 0 picks the port
`define IOX_KIND_IN 2'h0
`define IOX_KIND_OUT 2'h1
`define IOX_KIND_POL 2'h2
`define IOX_KIND_DIR 2'h3
`define IOX_OUT_RST 8'hff
`define IOX_POL_RST 8'h00
`define IOX_DIR_RST 8'hff
`endif

//--- core/iox_pkg.sv
package iox_pkg;
    typedef enum logic [2:0] {
        IOX_IDLE,
        IOX_ADDR,
        IOX_CMD,
        IOX_WR,
        IOX_ACK,
        IOX_RD,
        IOX_MACK
    } iox_state_t;

    typedef logic [7:0] iox_byte_t;

    typedef struct packed {
        iox_byte_t outv;
        iox_byte_t pol;
        iox_byte_t dir;
        iox_byte_t oe;
        iox_byte_t snap;
        logic primed;
    } iox_port_s_t;

    typedef struct packed {
        iox_state_t st;
        iox_state_t nxt;
        logic [2:0] cnt;
        logic full;
        iox_byte_t sh;
        logic [2:0] ptr;
        logic sda_oe;
        logic scl_p;
        logic sda_p;
        logic int_oe;
        logic low;
    } iox_top_s_t;
endpackage : iox_pkg

//--- core/iox_port.sv
`timescale 1ns/1ps
`include "iox_map.svh"
module iox_port #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register access
    input wire logic wr,
    input wire logic [1:0] kind,
    input wire iox_pkg::iox_byte_t wr_data,
    input wire logic cap,
    // pins
    input wire iox_pkg::iox_byte_t pin_in,
    output iox_pkg::iox_byte_t pin_out,
    output iox_pkg::iox_byte_t pin_oe,
    // read-back and change flag
    output iox_pkg::iox_byte_t in_val,
    output iox_pkg::iox_byte_t out_v,
    output iox_pkg::iox_byte_t pol_v,
    output iox_pkg::iox_byte_t dir_v,
    output logic mism
);
    import iox_pkg::*;

    if (WIDTH != 8) begin : g_chk
        $error("iox_port serves 8-bit ports only");
    end

    iox_port_s_t q, d;

    always_comb begin
        d = q;
        // first clock after reset takes the pins, so no false change shows
        if (!q.primed) begin
            d.primed = 1'b1;
            d.snap = pin_in;
        end else if (cap) begin
            d.snap = pin_in;
        end
        if (wr) begin
            unique case (kind)
                `IOX_KIND_IN: ;
                `IOX_KIND_OUT: d.outv = wr_data;
                `IOX_KIND_POL: d.pol = wr_data;
                `IOX_KIND_DIR: begin
                    d.dir = wr_data;
                    d.oe = ~wr_data;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{outv: `IOX_OUT_RST, pol: `IOX_POL_RST, dir: `IOX_DIR_RST,
                   oe: 8'h00, snap: 8'h00, primed: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign pin_out = q.outv;
    assign pin_oe = q.oe;
    assign in_val = pin_in ^ q.pol;
    assign out_v = q.outv;
    assign pol_v = q.pol;
    assign dir_v = q.dir;
    assign mism = q.primed && (pin_in != q.snap);

    property p_pol;
        @(posedge clock) disable iff (!rst_n) in_val == (pin_in ^ pol_v);
    endproperty
    a_pol: assert property (p_pol) else $error("input polarity wrong");

    property p_dir;
        @(posedge clock) disable iff (!rst_n) pin_oe == ~dir_v;
    endproperty
    a_dir: assert property (p_dir) else $error("drive does not follow direction");

    property p_inwr;
        @(posedge clock) disable iff (!rst_n)
            wr && kind == `IOX_KIND_IN |=> $stable(out_v) && $stable(pol_v) && $stable(dir_v);
    endproperty
    a_inwr: assert property (p_inwr) else $error("input register write took effect");

    property p_hold;
        @(posedge clock) disable iff (!rst_n) !wr |=> $stable(pin_out) && $stable(pin_oe);
    endproperty
    a_hold: assert property (p_hold) else $error("output latch changed unwritten");
endmodule : iox_port

//--- dv/iox_mst.sv
`timescale 1ns/1ps
module iox_mst (
    // clock
    input wire logic clock,
    // bus wires, released lines float high
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // 4 clocks per phase keeps clear of the 3-clock minimum
    task automatic hp();
        repeat (4) @(negedge clock);
    endtask : hp
    task automatic start();
        sda_low = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_low = 1'b1;
        hp();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        hp();
        sda_low = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_low = 1'b0;
        hp();
    endtask : stop
    // data moves only while the clock is low, never at its fall
    task automatic bitx(input logic b, output logic r);
        hp();
        sda_low = ~b;
        hp();
        scl = 1'b1;
        hp();
        r = sda;
        scl = 1'b0;
    endtask : bitx
    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r,
        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r[i]);
        end
        bitx(b9, a);
    endtask : xfer
endmodule : iox_mst

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import iox_pkg::*;
    // clock starts high so the reset edge below lands before the first rising edge
    logic clock = 1'b1;
    logic nrst = 1'b1;
    logic a_lo = 1'b0;
    logic a_hi = 1'b0;
    logic scl, m_low, sda, sda_out, sda_oe, int_n_out, int_n_oe, int_line, a;
    iox_byte_t ext0 = 8'h3c;
    iox_byte_t ext1 = 8'ha5;
    iox_byte_t p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe;
    logic [7:0] r;
    int error_cnt = 0;
    int total_checks = 0;
    assign sda = ~(m_low | (sda_oe & ~sda_out));
    assign int_line = int_n_oe ? int_n_out : 1'b1;
    // a driven pin reads back its own latch, an undriven one the outside level
    assign p0_in = (p0_oe & p0_out) | (~p0_oe & ext0);
    assign p1_in = (p1_oe & p1_out) | (~p1_oe & ext1);
    iox_mst mst (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));
    iox_top uut (.clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_sel_lo(a_lo), .addr_sel_hi(a_hi), .int_n_out(int_n_out),
        .int_n_oe(int_n_oe), .port0_pin_in(p0_in), .port0_pin_out(p0_out),
        .port0_pin_oe(p0_oe), .port1_pin_in(p1_in), .port1_pin_out(p1_out),
        .port1_pin_oe(p1_oe));
    initial begin
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    function automatic logic [7:0] dev(input logic rw);
        return {5'b11101, a_hi, a_lo, rw};
    endfunction : dev
    function automatic logic [7:0] in0();
        return ((~8'h56 & 8'h52) | (8'h56 & ext0)) ^ 8'h54;
    endfunction : in0
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic dat);
        mst.start();
        mst.xfer(dev(1'b0), 1'b1, r, a);
        chk(a, 8'h00);
        mst.xfer(c, 1'b1, r, a);
        chk(a, 8'h00);
        if (dat) begin
            mst.xfer(d, 1'b1, r, a);
            chk(a, 8'h00);
        end
        mst.stop();
    endtask : wr
    // two bytes per read: master ack then nack, both from the same register
    task automatic rd(input logic [7:0] c, input logic setc, input logic [7:0] exp);
        if (setc) begin
            wr(c, 8'h00, 1'b0);
        end
        mst.start();
        mst.xfer(dev(1'b1), 1'b1, r, a);
        chk(a, 8'h00);
        mst.xfer(8'hff, 1'b0, r, a);
        chk(r, exp);
        mst.xfer(8'hff, 1'b1, r, a);
        chk(r, exp);
        mst.stop();
    endtask : rd
    task automatic probe(input logic [7:0] b, input logic ack_n);
        mst.start();
        mst.xfer(b, 1'b1, r, a);
        mst.stop();
        chk(a, ack_n);
    endtask : probe
    task automatic t_defaults();
        chk(p0_oe, 8'h00);
        chk(p1_oe, 8'h00);
        chk(p0_out, 8'hff);
        chk(int_line, 8'h01);
        for (int c = 2; c < 8; c++) begin
            rd(c[7:0], 1'b1, (c < 4 || c > 5) ? 8'hff : 8'h00);
        end
    endtask : t_defaults
    task automatic t_regs();
        for (int c = 2; c < 8; c++) begin
            wr(c[7:0], 8'h50 | c[7:0], 1'b1);
            rd(c[7:0], 1'b1, 8'h50 | c[7:0]);
        end
        chk(p0_out, 8'h52);
        chk(p1_out, 8'h53);
        chk(p0_oe, ~8'h56);
        chk(p1_oe, ~8'h57);
        wr(8'h00, 8'h33, 1'b1);
        chk(p0_out, 8'h52);
        chk(p0_oe, ~8'h56);
        rd(8'h00, 1'b1, in0());
        rd(8'h01, 1'b1, ((~8'h57 & 8'h53) | (8'h57 & ext1)) ^ 8'h55);
        rd(8'h01, 1'b0, ((~8'h57 & 8'h53) | (8'h57 & ext1)) ^ 8'h55);
    endtask : t_regs
    task automatic t_int();
        chk(int_line, 8'h01);
        ext0 = ext0 ^ 8'h02;
        repeat (3) @(negedge clock);
        chk(int_line, 8'h00);
        chk(int_n_oe, 8'h01);
        rd(8'h00, 1'b1, in0());
        repeat (3) @(negedge clock);
        chk(int_line, 8'h01);
    endtask : t_int
    task automatic t_addr();
        for (int i = 0; i < 4; i++) begin
            {a_hi, a_lo} = i[1:0];
            probe(dev(1'b0), 1'b0);
            probe(dev(1'b0) ^ 8'h02, 1'b1);
            probe(dev(1'b0) ^ 8'h80, 1'b1);
        end
    endtask : t_addr
    // reset lands mid-transfer; the bus machine must come back idle
    task automatic t_rst();
        mst.start();
        mst.xfer(dev(1'b0), 1'b1, r, a);
        nrst = 1'b0;
        repeat (3) @(negedge clock);
        chk(p0_oe, 8'h00);
        chk(p1_out, 8'hff);
        chk(sda_oe, 8'h00);
        nrst = 1'b1;
        repeat (6) @(negedge clock);
        mst.stop();
        rd(8'h04, 1'b1, 8'h00);
        rd(8'h07, 1'b1, 8'hff);
    endtask : t_rst
    initial begin
        // a real falling reset edge, so no flop or assertion starts out unknown
        @(negedge clock);
        nrst = 1'b0;
        repeat (5) @(negedge clock);
        nrst = 1'b1;
        repeat (6) @(negedge clock);
        t_defaults();
        t_regs();
        t_int();
        t_addr();
        t_rst();
        results();
    end
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        results();
    end
endmodule : tb_top
